/* File: include/bmd_pkg.sv */
// Constants for the banked data-memory decoder and its RAM.
// Shared by the decoder, the core model, the checker and the bench; the RAM does not use it; no logic here.
package bmd_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned FILE_ADDR_W = 7;
  localparam int unsigned FULL_ADDR_W = 8;

  // Bank select lives in the status word
  localparam int unsigned BANK_BIT = 5;

  // Special-function slots take the low 32 addresses of a bank
  localparam logic [6:0] SFR_SPAN = 7'h20;

  // Shared slots, decoded on the low seven bits in either bank
  localparam logic [6:0] ADR_INDIRECT = 7'h00;
  localparam logic [6:0] ADR_PC_LOW = 7'h02;
  localparam logic [6:0] ADR_STATUS = 7'h03;
  localparam logic [6:0] ADR_FILE_SELECT = 7'h04;
  localparam logic [6:0] ADR_PC_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] ADR_INT_CONTROL = 7'h0B;

  // Bank 0 only
  localparam logic [7:0] ADR_TIMER_COUNT = 8'h01;
  localparam logic [7:0] ADR_FIRST_PORT = 8'h05;
  localparam logic [7:0] ADR_SECOND_PORT = 8'h06;

  // Bank 1 only
  localparam logic [7:0] ADR_TIMER_PRESCALE = 8'h81;
  localparam logic [7:0] ADR_FIRST_DIR = 8'h85;
  localparam logic [7:0] ADR_SECOND_DIR = 8'h86;
  localparam logic [7:0] ADR_POWER_CONTROL = 8'h8E;

  // General-purpose RAM windows
  localparam logic [7:0] B0_RAM_LO = 8'h20;
  localparam logic [7:0] B0_RAM_HI_SMALL = 8'h6F;
  localparam logic [7:0] B0_RAM_HI_LARGE = 8'h7F;
  localparam logic [7:0] B1_RAM_LO = 8'hA0;
  localparam logic [7:0] B1_RAM_HI = 8'hBF;
  // Bank 1 RAM follows bank 0 RAM in the array
  localparam logic [7:0] B1_IDX_BASE = 8'h60;

  localparam int unsigned RAM_DEPTH_SMALL = 80;
  localparam int unsigned RAM_DEPTH_LARGE = 128;

  // Quarter phases of the instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  // Hardware-owned status flags, not writable through the data path
  localparam logic [7:0] STATUS_RO_MASK = 8'h18;

  localparam logic [7:0] RST_SFR = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

/* File: logic/bmd_decoder.sv */
// Banked data-memory decoder with special-function register file.
// Partner is the core execute stage on clk_sys_in; it drives
// file_addr_in and the enables for the one quarter that takes them.
`timescale 1ns/1ns
`default_nettype none

module bmd_decoder
  import bmd_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int unsigned RAM_DEPTH = 128
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [bmd_pkg::FILE_ADDR_W-1:0] file_addr_in,
  input wire logic rd_en_in,
  input wire logic wr_en_in,
  input wire logic [bmd_pkg::DATA_W-1:0] wr_data_in,
  output logic [1:0] quarter_out,
  output logic [bmd_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic wr_ignored_out,
  output logic bank_select_bit_out,
  output logic [bmd_pkg::DATA_W-1:0] timer_count_out,
  output logic [bmd_pkg::DATA_W-1:0] program_counter_low_out,
  output logic [bmd_pkg::DATA_W-1:0] status_word_out,
  output logic [bmd_pkg::DATA_W-1:0] file_select_pointer_out,
  output logic [bmd_pkg::DATA_W-1:0] first_io_port_out,
  output logic [bmd_pkg::DATA_W-1:0] second_io_port_out,
  output logic [bmd_pkg::DATA_W-1:0] program_counter_high_latch_out,
  output logic [bmd_pkg::DATA_W-1:0] interrupt_control_out,
  output logic [bmd_pkg::DATA_W-1:0] timer_prescale_settings_out,
  output logic [bmd_pkg::DATA_W-1:0] first_port_direction_out,
  output logic [bmd_pkg::DATA_W-1:0] second_port_direction_out,
  output logic [bmd_pkg::DATA_W-1:0] power_control_out
);
  import bmd_pkg::*;

  localparam int unsigned IDX_W = $clog2(RAM_DEPTH);

  if (RAM_DEPTH != (LARGE_VARIANT ? RAM_DEPTH_LARGE : RAM_DEPTH_SMALL))
  begin : g_depth_chk
    $error("bmd_decoder: RAM_DEPTH does not match the variant");
  end

  // Whole register state: one comb copy, one flop stage
  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] timer_count;
    logic [7:0] pc_low;
    logic [7:0] status;
    logic [7:0] file_select;
    logic [7:0] first_port;
    logic [7:0] second_port;
    logic [7:0] pc_high_latch;
    logic [7:0] int_control;
    logic [7:0] timer_prescale;
    logic [7:0] first_dir;
    logic [7:0] second_dir;
    logic [7:0] power_control;
    logic [7:0] rd_data;
    logic rd_valid;
    logic wr_ignored;
  } bmd_state_t;

  bmd_state_t state_q;
  bmd_state_t state_d;

  logic [7:0] eff_addr;
  logic ram_sel;
  logic [IDX_W-1:0] ram_idx;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic rd_now;
  logic wr_now;

  // True when the full address falls in implemented RAM
  function automatic logic ram_hit(input logic [7:0] a);
    logic [7:0] b0_top;
    b0_top = LARGE_VARIANT ? B0_RAM_HI_LARGE : B0_RAM_HI_SMALL;
    if (a >= B0_RAM_LO && a <= b0_top)
    begin
      return 1'b1;
    end
    if (LARGE_VARIANT && a >= B1_RAM_LO && a <= B1_RAM_HI)
    begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  // Packs both RAM windows into one contiguous array index
  function automatic logic [7:0] ram_index(input logic [7:0] a);
    logic [7:0] idx;
    if (a[7])
    begin
      idx = 8'(a - B1_RAM_LO + B1_IDX_BASE);
    end
    else
    begin
      idx = 8'(a - B0_RAM_LO);
    end
    return idx;
  endfunction

  // Common slots decode on the low bits alone
  function automatic logic is_shared(input logic [7:0] a,
                                     input logic [6:0] slot);
    return a[6:0] == slot;
  endfunction

  // Special-function read; anything unmapped answers zero
  function automatic logic [7:0] sfr_read(input bmd_state_t s,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = READ_ZERO;
    if (is_shared(a, ADR_PC_LOW))
    begin
      v = s.pc_low;
    end
    else if (is_shared(a, ADR_STATUS))
    begin
      v = s.status;
    end
    else if (is_shared(a, ADR_FILE_SELECT))
    begin
      v = s.file_select;
    end
    else if (is_shared(a, ADR_PC_HIGH_LATCH))
    begin
      v = s.pc_high_latch;
    end
    else if (is_shared(a, ADR_INT_CONTROL))
    begin
      v = s.int_control;
    end
    else
    begin
      case (a)
        ADR_TIMER_COUNT: v = s.timer_count;
        ADR_FIRST_PORT: v = s.first_port;
        ADR_SECOND_PORT: v = s.second_port;
        ADR_TIMER_PRESCALE: v = s.timer_prescale;
        ADR_FIRST_DIR: v = s.first_dir;
        ADR_SECOND_DIR: v = s.second_dir;
        ADR_POWER_CONTROL: v = s.power_control;
        default: v = READ_ZERO;
      endcase
    end
    return v;
  endfunction

  // Pointer port holds nothing; it redirects to the pointer's address.
  // A pointer aimed at the port itself lands on a zero read.
  always_comb
  begin
    if (file_addr_in == ADR_INDIRECT)
    begin
      eff_addr = state_q.file_select;
    end
    else
    begin
      eff_addr = {state_q.status[BANK_BIT], file_addr_in};
    end
  end

  // RAM and register slots never overlap, so a write has one target
  assign ram_sel = ram_hit(eff_addr);
  assign ram_idx = IDX_W'(ram_index(eff_addr));
  assign rd_now = rd_en_in && (state_q.phase == PH_Q2);
  assign wr_now = wr_en_in && (state_q.phase == PH_Q4);
  assign ram_we = wr_now && ram_sel;

  bmd_gp_ram #(
    .WIDTH(DATA_W),
    .DEPTH(RAM_DEPTH),
    .IDX_W(IDX_W)
  ) u_ram (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(ram_we),
    .idx_in(ram_idx),
    .wr_data_in(wr_data_in),
    .rd_data_out(ram_rdata)
  );

  always_comb
  begin
    state_d = state_q;
    state_d.phase = 2'(state_q.phase + PH_STEP);
    state_d.rd_valid = 1'b0;
    state_d.wr_ignored = 1'b0;

    // Result stands until the next taken read or a reset, which loads zero
    if (rd_now)
    begin
      state_d.rd_valid = 1'b1;
      if (ram_sel)
      begin
        state_d.rd_data = ram_rdata;
      end
      else
      begin
        state_d.rd_data = sfr_read(state_q, eff_addr);
      end
    end

    // Shared slots first; bank-only slots decode on all eight bits
    if (wr_now && !ram_sel)
    begin
      if (is_shared(eff_addr, ADR_PC_LOW))
      begin
        state_d.pc_low = wr_data_in;
      end
      else if (is_shared(eff_addr, ADR_STATUS))
      begin
        // Flag bits owned by hardware survive a data-path write
        state_d.status = (wr_data_in & ~STATUS_RO_MASK)
                       | (state_q.status & STATUS_RO_MASK);
      end
      else if (is_shared(eff_addr, ADR_FILE_SELECT))
      begin
        state_d.file_select = wr_data_in;
      end
      else if (is_shared(eff_addr, ADR_PC_HIGH_LATCH))
      begin
        state_d.pc_high_latch = wr_data_in;
      end
      else if (is_shared(eff_addr, ADR_INT_CONTROL))
      begin
        state_d.int_control = wr_data_in;
      end
      else
      begin
        case (eff_addr)
          ADR_TIMER_COUNT: state_d.timer_count = wr_data_in;
          ADR_FIRST_PORT: state_d.first_port = wr_data_in;
          ADR_SECOND_PORT: state_d.second_port = wr_data_in;
          ADR_TIMER_PRESCALE: state_d.timer_prescale = wr_data_in;
          ADR_FIRST_DIR: state_d.first_dir = wr_data_in;
          ADR_SECOND_DIR: state_d.second_dir = wr_data_in;
          ADR_POWER_CONTROL: state_d.power_control = wr_data_in;
          default: state_d.wr_ignored = 1'b1;
        endcase
      end
    end

    // Reset last, so it overrides a register request in the same cycle; a RAM write in that cycle still lands.
    // RAM is left alone: it keeps whatever contents it held before reset.
    if (sys_rst_in)
    begin
      state_d = '0;
      state_d.phase = PH_Q1;
      state_d.timer_count = RST_SFR;
      state_d.pc_low = RST_SFR;
      state_d.status = RST_SFR;
      state_d.file_select = RST_SFR;
      state_d.first_port = RST_SFR;
      state_d.second_port = RST_SFR;
      state_d.pc_high_latch = RST_SFR;
      state_d.int_control = RST_SFR;
      state_d.timer_prescale = RST_SFR;
      state_d.first_dir = RST_SFR;
      state_d.second_dir = RST_SFR;
      state_d.power_control = RST_SFR;
      state_d.rd_data = READ_ZERO;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    state_q <= state_d;
  end

  // Quarter runs free, so a held request waits for its own quarter
  assign quarter_out = state_q.phase;
  assign rd_data_out = state_q.rd_data;
  assign rd_valid_out = state_q.rd_valid;
  assign wr_ignored_out = state_q.wr_ignored;
  assign bank_select_bit_out = state_q.status[BANK_BIT];
  assign timer_count_out = state_q.timer_count;
  assign program_counter_low_out = state_q.pc_low;
  assign status_word_out = state_q.status;
  assign file_select_pointer_out = state_q.file_select;
  assign first_io_port_out = state_q.first_port;
  assign second_io_port_out = state_q.second_port;
  assign program_counter_high_latch_out = state_q.pc_high_latch;
  assign interrupt_control_out = state_q.int_control;
  assign timer_prescale_settings_out = state_q.timer_prescale;
  assign first_port_direction_out = state_q.first_dir;
  assign second_port_direction_out = state_q.second_dir;
  assign power_control_out = state_q.power_control;

endmodule // bmd_decoder

`default_nettype wire

/* File: logic/bmd_gp_ram.sv */
// General-purpose static RAM array for the data-memory decoder.
// One index port: the decoder never reads and writes in one cycle.
`timescale 1ns/1ns
`default_nettype none

module bmd_gp_ram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 128,
  parameter int unsigned IDX_W = 7
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] idx_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  if (DEPTH > (1 << IDX_W))
  begin : g_chk
    $error("bmd_gp_ram: index too narrow for depth");
  end

  // No reset: contents are undefined after power-up, as for real SRAM
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem_q[idx_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem_q[idx_in];

endmodule // bmd_gp_ram

`default_nettype wire

/* File: verif/bmd_core_model.sv */
// Execute-stage model: operand read in Q2, destination write in Q4.
// Follows quarter_out; released lines show inverted last values.
`timescale 1ns/1ns
`default_nettype none
module bmd_core_model
  import bmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [1:0] quarter_in,
  input wire logic [7:0] rd_data_in,
  output logic [6:0] file_addr_out,
  output logic rd_en_out,
  output logic wr_en_out,
  output logic [7:0] wr_data_out
);
  initial
  begin
    file_addr_out = 7'h00;
    rd_en_out = 1'b0;
    wr_en_out = 1'b0;
    wr_data_out = 8'h00;
  end
  // Raise at the edge leaving quarter q, so the next edge takes it.
  // Quarter is read settled, never in the time step of its own edge.
  task automatic go(input logic [1:0] q);
    #1;
    while (quarter_in !== q)
    begin
      @(posedge clk_sys_in);
      #1;
    end
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    go(PH_Q1);
    file_addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_out <= 1'b0;
    file_addr_out <= ~a;
    #1;
    d = rd_data_in;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    go(PH_Q4 - PH_STEP);
    file_addr_out <= a;
    wr_data_out <= v;
    wr_en_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_out <= 1'b0;
    file_addr_out <= ~a;
    wr_data_out <= ~v;
    #1;
  endtask
endmodule // bmd_core_model
`default_nettype wire

/* File: verif/bmd_decoder_chk.sv */
// Port checks for the banked data-memory decoder.
// Bound into every decoder instance; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
module bmd_decoder_chk
  import bmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [6:0] file_addr_in,
  input wire logic rd_en_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [1:0] quarter_out,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic wr_ignored_out,
  input wire logic bank_select_bit_out,
  input wire logic [7:0] status_word_out,
  input wire logic [7:0] timer_count_out,
  input wire logic [7:0] timer_prescale_settings_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic rd_q2;
  logic wr_q4;
  logic hole;
  assign rd_q2 = quarter_out == PH_Q2 && rd_en_in;
  assign wr_q4 = quarter_out == PH_Q4 && wr_en_in;
  // Direct holes only; pointer targets are judged by the bench
  assign hole = file_addr_in inside {[7'h07:7'h09], 7'h0C, 7'h0D,
    [7'h0F:7'h1F]} || (bank_select_bit_out && file_addr_in >= 7'h40);
  AST_QUARTER: assert property (
    !$past(sys_rst_in) |-> quarter_out == $past(quarter_out) + 2'h1)
    else $error("quarter skipped");
  AST_RD_PULSE: assert property (rd_q2 |=> rd_valid_out)
    else $error("read not answered");
  AST_RD_NONE: assert property (!rd_q2 |=> !rd_valid_out)
    else $error("stray read valid");
  AST_BANK: assert property (
    wr_q4 && !bank_select_bit_out && file_addr_in == 7'h01 |=>
    timer_count_out == $past(wr_data_in) &&
    $stable(timer_prescale_settings_out))
    else $error("bank zero slot misrouted");
  AST_HOLE_RD: assert property (
    rd_q2 && hole |=> rd_data_out == READ_ZERO)
    else $error("hole read not zero");
  AST_HOLE_WR: assert property (wr_q4 && hole |=> wr_ignored_out)
    else $error("hole write not ignored");
  AST_STATUS: assert property (
    wr_q4 && file_addr_in == ADR_STATUS |=> status_word_out ==
    ($past(wr_data_in) & ~STATUS_RO_MASK |
    $past(status_word_out) & STATUS_RO_MASK))
    else $error("status write wrong");
  AST_BANK1_ONLY: assert property (
    wr_q4 && bank_select_bit_out && file_addr_in == 7'h01 |=>
    timer_prescale_settings_out == $past(wr_data_in) &&
    $stable(timer_count_out))
    else $error("bank one slot misrouted");
  cover property (rd_q2 && hole);
  cover property (wr_q4 && bank_select_bit_out);
  cover property (wr_q4 && file_addr_in == ADR_INDIRECT);
endmodule // bmd_decoder_chk
bind bmd_decoder bmd_decoder_chk chk_u (
  .clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in),
  .file_addr_in(file_addr_in),
  .rd_en_in(rd_en_in),
  .wr_en_in(wr_en_in),
  .wr_data_in(wr_data_in),
  .quarter_out(quarter_out),
  .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out),
  .wr_ignored_out(wr_ignored_out),
  .bank_select_bit_out(bank_select_bit_out),
  .status_word_out(status_word_out),
  .timer_count_out(timer_count_out),
  .timer_prescale_settings_out(timer_prescale_settings_out)
);
`default_nettype wire

/* File: verif/test_banked_data_memory_decoder.sv */
// Bench: large and small decoders fed by one execute-stage model.
// Reads dut outputs hierarchically; small variant shadows each access.
`timescale 1ns/1ns
`default_nettype none
module test_banked_data_memory_decoder;
  import bmd_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [6:0] addr;
  logic rd_en;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [1:0] qtr;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  bmd_core_model core_u (.clk_sys_in(clk_sys_in), .quarter_in(qtr),
    .rd_data_in(rdata), .file_addr_out(addr), .rd_en_out(rd_en),
    .wr_en_out(wr_en), .wr_data_out(wdata));
  bmd_decoder dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .file_addr_in(addr), .rd_en_in(rd_en), .wr_en_in(wr_en),
    .wr_data_in(wdata), .quarter_out(qtr), .rd_data_out(rdata),
    .rd_valid_out(), .wr_ignored_out(), .bank_select_bit_out(),
    .timer_count_out(), .program_counter_low_out(), .status_word_out(),
    .file_select_pointer_out(), .first_io_port_out(),
    .second_io_port_out(), .program_counter_high_latch_out(),
    .interrupt_control_out(), .timer_prescale_settings_out(),
    .first_port_direction_out(), .second_port_direction_out(),
    .power_control_out());
  bmd_decoder #(.LARGE_VARIANT(1'b0), .RAM_DEPTH(80)) small_u (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .file_addr_in(addr), .rd_en_in(rd_en), .wr_en_in(wr_en),
    .wr_data_in(wdata), .quarter_out(), .rd_data_out(),
    .rd_valid_out(), .wr_ignored_out(), .bank_select_bit_out(),
    .timer_count_out(), .program_counter_low_out(), .status_word_out(),
    .file_select_pointer_out(), .first_io_port_out(),
    .second_io_port_out(), .program_counter_high_latch_out(),
    .interrupt_control_out(), .timer_prescale_settings_out(),
    .first_port_direction_out(), .second_port_direction_out(),
    .power_control_out());
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wri(input logic [6:0] a, input logic [7:0] v,
      input logic ign);
    core_u.wr(a, v);
    chk({7'h00, dut_u.wr_ignored_out}, {7'h00, ign});
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e,
      input logic [7:0] se);
    logic [7:0] d;
    core_u.rd(a, d);
    chk(d, e);
    chk({7'h00, dut_u.rd_valid_out}, 8'h01);
    chk(small_u.rd_data_out, se);
  endtask
  task automatic bank(input logic b);
    wri(ADR_STATUS, {2'h0, b, 5'h00}, 1'b0);
    chk({7'h00, dut_u.bank_select_bit_out}, {7'h00, b});
  endtask
  task automatic t_reset();
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1;
    chk({6'h00, qtr}, 8'h00);
    chk(dut_u.status_word_out, RST_SFR);
    chk(dut_u.power_control_out, RST_SFR);
    chk(dut_u.first_port_direction_out, RST_SFR);
  endtask
  task automatic t_banked();
    logic [6:0] adr [4] = '{7'h01, 7'h05, 7'h06, 7'h0E};
    for (int i = 0; i < 4; i++)
    begin
      bank(1'b1);
      wri(adr[i], 8'hA0 + 8'(i), 1'b0);
      bank(1'b0);
      wri(adr[i], 8'h50 + 8'(i), i == 3);
    end
    chk(dut_u.timer_count_out, 8'h50);
    chk(dut_u.second_io_port_out, 8'h52);
    chk(dut_u.timer_prescale_settings_out, 8'hA0);
    chk(dut_u.power_control_out, 8'hA3);
    chk(dut_u.first_io_port_out, 8'h51);
    chk(dut_u.first_port_direction_out, 8'hA1);
    chk(dut_u.second_port_direction_out, 8'hA2);
    rdc(7'h0E, 8'h00, 8'h00);
  endtask
  task automatic t_shared();
    logic [6:0] sh [4] = '{ADR_FILE_SELECT, ADR_PC_HIGH_LATCH,
      ADR_INT_CONTROL, ADR_PC_LOW};
    bank(1'b1);
    foreach (sh[i]) wri(sh[i], 8'h30 + 8'(i), 1'b0);
    chk(dut_u.file_select_pointer_out, 8'h30);
    chk(dut_u.program_counter_high_latch_out, 8'h31);
    chk(dut_u.interrupt_control_out, 8'h32);
    chk(dut_u.program_counter_low_out, 8'h33);
    bank(1'b0);
    foreach (sh[i]) rdc(sh[i], 8'h30 + 8'(i), 8'h30 + 8'(i));
  endtask
  task automatic t_ram();
    wri(7'h20, 8'h11, 1'b0);
    wri(7'h7F, 8'h22, 1'b0);
    wri(7'h6F, 8'h66, 1'b0);
    bank(1'b1);
    wri(7'h20, 8'h33, 1'b0);
    wri(7'h3F, 8'h44, 1'b0);
    rdc(7'h20, 8'h33, 8'h00);
    rdc(7'h3F, 8'h44, 8'h00);
    bank(1'b0);
    rdc(7'h20, 8'h11, 8'h11);
    rdc(7'h7F, 8'h22, 8'h00);
    rdc(7'h6F, 8'h66, 8'h66);
  endtask
  task automatic t_indirect();
    wri(ADR_FILE_SELECT, 8'hA5, 1'b0);
    wri(ADR_INDIRECT, 8'h77, 1'b0);
    bank(1'b1);
    rdc(7'h25, 8'h77, 8'h00);
    bank(1'b0);
    wri(ADR_FILE_SELECT, 8'h20, 1'b0);
    rdc(ADR_INDIRECT, 8'h11, 8'h11);
    wri(ADR_FILE_SELECT, 8'h80, 1'b0);
    wri(ADR_INDIRECT, 8'h99, 1'b1);
    rdc(ADR_INDIRECT, 8'h00, 8'h00);
  endtask
  task automatic t_holes();
    logic [6:0] hole [4] = '{7'h07, 7'h0C, 7'h1F, 7'h40};
    bank(1'b1);
    foreach (hole[i])
    begin
      wri(hole[i], 8'hFF, 1'b1);
      rdc(hole[i], 8'h00, 8'h00);
    end
    chk(dut_u.status_word_out, 8'h20);
    wri(ADR_STATUS, 8'hFF, 1'b0);
    chk(dut_u.status_word_out, 8'hE7);
    bank(1'b0);
  endtask
  task automatic final_report();
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_banked();
    t_shared();
    t_ram();
    t_indirect();
    t_holes();
    t_reset();
    final_report();
  end
  // Whole run is well under a thousand cycles
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      final_report();
    end
  end
endmodule // test_banked_data_memory_decoder
`default_nettype wire
